// ### mps_host_model.sv
`timescale 1ns/1ps
// host side: straps, trigger level and pull-ups on released pins
module mps_host_model (
   input wire logic want_i2c,
   input wire logic addr_lsb,
   input wire logic kick_level,
   input wire logic addr_o,
   input wire logic addr_oe,
   input wire logic kick_o,
   input wire logic kick_oe,
   input wire logic irq2_o,
   input wire logic irq2_oe,
   input wire logic sda_oe,
   output logic select_bar_pin,
   output logic addr_pin,
   output logic kick_pin,
   output logic irq2_pin,
   output logic sda_pin
);
   assign select_bar_pin = want_i2c;
   assign addr_pin = addr_oe ? addr_o : addr_lsb;
   // trigger tied to a fixed level by the host when unused
   assign kick_pin = kick_oe ? kick_o : kick_level;
   assign irq2_pin = irq2_oe ? irq2_o : 1'h1;
   // open drain with pull-up
   assign sda_pin = sda_oe ? 1'h0 : 1'h1;
endmodule // mps_host_model

// ### mps_pin_mux.sv
`timescale 1ns/1ps
// How it works
// - strap level selects SPI or I2C host mode
// - shared pin is address bit or SPI output
// - align pin floats until software enables drive
// - both fields zero: irq2 and trigger input
// - mode nonzero, irq2 select clear: align on shared pin
// - irq2 select: align on second irq pin
// - trigger input starts buffer actions
// - sample buffer holds 4096 bytes
// - one rate and range set for sleep/wake
// - gyro range selectable 64 to 2048 dps
// - auxiliary bus master drives clock and data
module mps_pin_mux (
   input wire logic clock,
   input wire logic rst,
   input wire logic select_bar_pin,
   input wire logic out_or_addr_bit_pin,
   input wire logic spi_data_out,
   input wire logic spi_data_oe,
   output logic out_or_addr_bit_o,
   output logic out_or_addr_bit_oe,
   output logic host_is_i2c,
   output logic slave_addr_lsb,
   input wire logic cfg_write,
   input wire logic align_on_irq2_select,
   input wire logic [1:0] align_function_select,
   input wire logic align_output_enable,
   input wire logic [2:0] gyro_range_select,
   input wire logic [3:0] output_rate_select,
   output logic [2:0] gyro_range,
   output logic [3:0] output_rate,
   input wire logic irq1,
   input wire logic irq2,
   input wire logic align_out,
   output logic align_in,
   output logic align_enabled,
   output logic first_irq_pin,
   input wire logic second_irq_pin_i,
   output logic second_irq_pin_o,
   output logic second_irq_pin_oe,
   input wire logic shared_align_kick_pin_i,
   output logic shared_align_kick_pin_o,
   output logic shared_align_kick_pin_oe,
   output logic buffer_trigger,
   output logic [11:0] buffer_capacity_m1,
   input wire logic side_scl_out,
   input wire logic side_sda_out,
   output logic side_bus_clock_pin_o,
   output logic side_bus_clock_pin_oe,
   input wire logic side_bus_data_pin_i,
   output logic side_bus_data_pin_o,
   output logic side_bus_data_pin_oe,
   output logic side_sda_in
);
   mps_pkg::mps_host_mode_t mode;
   mps_pkg::mps_route_t route;
   mps_pkg::mps_route_t next_route;
   logic strap_level;
   logic addr_level;
   logic kick_level;
   logic irq2_level;
   logic strap_done;
   logic on_irq2;
   logic [1:0] func_sel;
   logic drive_en;
   logic [2:0] settle;
   logic kick_prev;

   mps_sync3 u_strap (
      .clock(clock),
      .rst(rst),
      .pin(select_bar_pin),
      .level(strap_level)
   );

   mps_sync3 u_addr (
      .clock(clock),
      .rst(rst),
      .pin(out_or_addr_bit_pin),
      .level(addr_level)
   );

   mps_sync3 u_kick (
      .clock(clock),
      .rst(rst),
      .pin(shared_align_kick_pin_i),
      .level(kick_level)
   );

   mps_sync3 u_irq2in (
      .clock(clock),
      .rst(rst),
      .pin(second_irq_pin_i),
      .level(irq2_level)
   );

   mps_sync3 u_side (
      .clock(clock),
      .rst(rst),
      .pin(side_bus_data_pin_i),
      .level(side_sda_in)
   );

   // strap latched once, after the synchroniser has filled
   always_ff @(posedge clock) begin
      if (rst) begin
         mode <= mps_pkg::MPS_MODE_SPI;
         strap_done <= 1'b0;
         settle <= '0;
         slave_addr_lsb <= 1'b0;
      end else if (!strap_done) begin
         settle <= settle + 3'h1;
         if (settle == 3'(mps_pkg::MPS_SETTLE_CYCLES)) begin
            strap_done <= 1'b1;
            mode <= strap_level ? mps_pkg::MPS_MODE_I2C
                                : mps_pkg::MPS_MODE_SPI;
            slave_addr_lsb <= addr_level;
         end
      end
   end

   assign host_is_i2c = (mode == mps_pkg::MPS_MODE_I2C);

   // in I2C mode the pin is only an address strap, never driven
   always_ff @(posedge clock) begin
      if (rst) begin
         out_or_addr_bit_o <= 1'b0;
         out_or_addr_bit_oe <= 1'b0;
      end else begin
         out_or_addr_bit_o <= spi_data_out;
         out_or_addr_bit_oe <= strap_done && !host_is_i2c
                               && spi_data_oe;
      end
   end

   // control fields held only on a write, so routing moves once
   always_ff @(posedge clock) begin
      if (rst) begin
         on_irq2 <= mps_pkg::MPS_ON_IRQ2_RESET;
         func_sel <= mps_pkg::MPS_MODE_FIELD_RESET;
         drive_en <= mps_pkg::MPS_ALIGN_OE_RESET;
         gyro_range <= mps_pkg::MPS_RANGE_RESET;
         output_rate <= '0;
      end else if (cfg_write) begin
         on_irq2 <= align_on_irq2_select;
         func_sel <= align_function_select;
         drive_en <= align_output_enable;
         // out-of-range codes keep the previous range
         if (gyro_range_select <= mps_pkg::MPS_RANGE_MAX) begin
            gyro_range <= gyro_range_select;
         end
         output_rate <= output_rate_select;
      end
   end

   always_comb begin
      if (on_irq2) begin
         next_route = mps_pkg::MPS_ROUTE_ALIGN_TRIG;
      end else if (func_sel != 2'h0) begin
         next_route = mps_pkg::MPS_ROUTE_IRQ_ALIGN;
      end else begin
         next_route = mps_pkg::MPS_ROUTE_IRQ_TRIG;
      end
   end

   // registered route: one clean switch per write, no combinational hazard
   always_ff @(posedge clock) begin
      if (rst) begin
         route <= mps_pkg::MPS_ROUTE_IRQ_TRIG;
      end else begin
         route <= next_route;
      end
   end

   // all pin drives from flip-flops so a route change cannot glitch
   always_ff @(posedge clock) begin
      if (rst) begin
         first_irq_pin <= 1'b0;
         second_irq_pin_o <= 1'b0;
         second_irq_pin_oe <= 1'b0;
         shared_align_kick_pin_o <= 1'b0;
         shared_align_kick_pin_oe <= 1'b0;
         align_in <= 1'b0;
         align_enabled <= 1'b0;
      end else begin
         first_irq_pin <= irq1;
         unique case (route)
            mps_pkg::MPS_ROUTE_IRQ_TRIG: begin
               second_irq_pin_o <= irq2;
               second_irq_pin_oe <= 1'b1;
               shared_align_kick_pin_o <= 1'b0;
               shared_align_kick_pin_oe <= 1'b0;
               align_in <= 1'b0;
               align_enabled <= 1'b0;
            end
            mps_pkg::MPS_ROUTE_IRQ_ALIGN: begin
               second_irq_pin_o <= irq2;
               second_irq_pin_oe <= 1'b1;
               shared_align_kick_pin_o <= align_out;
               shared_align_kick_pin_oe <= drive_en;
               align_in <= drive_en ? 1'b0 : kick_level;
               align_enabled <= 1'b1;
            end
            mps_pkg::MPS_ROUTE_ALIGN_TRIG: begin
               second_irq_pin_o <= align_out;
               second_irq_pin_oe <= drive_en;
               shared_align_kick_pin_o <= 1'b0;
               shared_align_kick_pin_oe <= 1'b0;
               align_in <= drive_en ? 1'b0 : irq2_level;
               align_enabled <= 1'b1;
            end
         endcase
      end
   end

   // rising edge on the trigger input while it is routed as trigger
   always_ff @(posedge clock) begin
      if (rst) begin
         kick_prev <= 1'b0;
         buffer_trigger <= 1'b0;
      end else begin
         kick_prev <= kick_level;
         // a trigger tied high rises in the synchroniser after reset;
         // no edge counts until the straps have settled
         buffer_trigger <= strap_done && kick_level && !kick_prev
                           && route != mps_pkg::MPS_ROUTE_IRQ_ALIGN;
      end
   end

   assign buffer_capacity_m1 =
      12'(mps_pkg::MPS_BUFFER_BYTES - 1);

   // open-drain master: drive low only, release for high
   always_ff @(posedge clock) begin
      if (rst) begin
         side_bus_clock_pin_o <= 1'b0;
         side_bus_clock_pin_oe <= 1'b0;
         side_bus_data_pin_o <= 1'b0;
         side_bus_data_pin_oe <= 1'b0;
      end else begin
         side_bus_clock_pin_oe <= !side_scl_out;
         side_bus_data_pin_oe <= !side_sda_out;
      end
   end

   chk_align_float_reset: assert property (@(posedge clock)
      $fell(rst) |-> !second_irq_pin_oe[*1] ##0 !shared_align_kick_pin_oe)
      else $error("align pin driven after reset");

   chk_route_irq_trig: assert property (@(posedge clock) disable iff (rst)
      (!on_irq2 && func_sel == 2'h0) |-> ##2
      (second_irq_pin_o == $past(irq2) && second_irq_pin_oe))
      else $error("irq2 not routed");

   chk_route_align_shared: assert property (@(posedge clock)
      disable iff (rst)
      (route == mps_pkg::MPS_ROUTE_IRQ_ALIGN) |=> second_irq_pin_oe
      && align_enabled && shared_align_kick_pin_oe == $past(drive_en))
      else $error("align not on shared pin");

   chk_route_align_irq2: assert property (@(posedge clock) disable iff (rst)
      on_irq2 |-> ##2 (route == mps_pkg::MPS_ROUTE_ALIGN_TRIG
      || !$past(on_irq2)) && !shared_align_kick_pin_oe)
      else $error("align not on irq2 pin");

   chk_no_drive_off: assert property (@(posedge clock) disable iff (rst)
      !drive_en |=> !shared_align_kick_pin_oe)
      else $error("align driven without enable");

   chk_addr_no_drive: assert property (@(posedge clock) disable iff (rst)
      host_is_i2c |=> !out_or_addr_bit_oe)
      else $error("address pin driven in I2C");

   chk_mode_stable: assert property (@(posedge clock) disable iff (rst)
      strap_done |=> $stable(mode))
      else $error("host mode changed");

   chk_trig_masked: assert property (@(posedge clock) disable iff (rst)
      buffer_trigger |-> $past(route) != mps_pkg::MPS_ROUTE_IRQ_ALIGN)
      else $error("trigger while align on pin");

   chk_range_legal: assert property (@(posedge clock) disable iff (rst)
      gyro_range <= mps_pkg::MPS_RANGE_MAX)
      else $error("illegal gyro range");

   chk_side_clock: assert property (@(posedge clock) disable iff (rst)
      !side_scl_out |=> side_bus_clock_pin_oe && !side_bus_clock_pin_o)
      else $error("side clock not pulled low");
endmodule // mps_pin_mux

// ### mps_pkg.sv
package mps_pkg;
   // host interface mode taken from the select strap
   typedef enum logic {
      MPS_MODE_SPI,
      MPS_MODE_I2C
   } mps_host_mode_t;

   // routing of the two multifunction pins
   typedef enum logic [1:0] {
      MPS_ROUTE_IRQ_TRIG,
      MPS_ROUTE_IRQ_ALIGN,
      MPS_ROUTE_ALIGN_TRIG
   } mps_route_t;

   localparam int MPS_MODE_FIELD_W = 2;
   localparam logic [1:0] MPS_MODE_FIELD_RESET = 2'h0;
   localparam logic MPS_ON_IRQ2_RESET = 1'h0;
   localparam logic MPS_ALIGN_OE_RESET = 1'h0;
   localparam int MPS_BUFFER_BYTES = 4096;
   localparam int MPS_BUFFER_AW = 12;
   localparam int MPS_RANGE_W = 3;
   localparam logic [2:0] MPS_RANGE_RESET = 3'h2;
   localparam logic [2:0] MPS_RANGE_MAX = 3'h5;
   // the pin synchroniser shows a valid level only from the fourth edge on
   localparam int MPS_SETTLE_CYCLES = 4;
endpackage

// ### mps_sync3.sv
`timescale 1ns/1ps
// three-stage pin synchroniser; output changes once stages two and three agree
module mps_sync3 (
   input wire logic clock,
   input wire logic rst,
   input wire logic pin,
   output logic level
);
   logic s1;
   logic s2;
   logic s3;

   always_ff @(posedge clock) begin
      if (rst) begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
      end else begin
         s1 <= pin;
         s2 <= s1;
         s3 <= s2;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         level <= 1'b0;
      end else if (s2 == s3) begin
         level <= s3;
      end
   end
endmodule // mps_sync3

// ### tb_mps_pin_mux.sv
`timescale 1ns/1ps
module tb_mps_pin_mux;
   logic clock = 0, rst = 1, want_i2c = 0, addr_lsb = 0, kick_level = 0;
   logic spi_do = 0, spi_oe = 0, cfg_write = 0, on2 = 0, en = 0;
   logic irq1 = 0, irq2 = 1, al_out = 0, scl = 1, sda = 1;
   logic [1:0] mode = 0;
   logic [2:0] rng = 0, grng;
   logic [3:0] rate = 0, orate;
   logic sel, apin, ao, aoe, i2c, alsb, al_in, al_en, irq1_p, i2p, i2o, i2oe;
   logic kp, ko, koe, trig, sclo, scloe, sdap, sdao, sdaoe, sdain;
   logic [11:0] cap;
   int n_fail = 0, n_checks = 0;
   always #4 clock = ~clock;
   mps_host_model u_host (.want_i2c(want_i2c), .addr_lsb(addr_lsb),
      .kick_level(kick_level), .addr_o(ao), .addr_oe(aoe), .kick_o(ko),
      .kick_oe(koe), .irq2_o(i2o), .irq2_oe(i2oe), .sda_oe(sdaoe),
      .select_bar_pin(sel), .addr_pin(apin), .kick_pin(kp), .irq2_pin(i2p),
      .sda_pin(sdap));
   mps_pin_mux u_dut (.clock(clock), .rst(rst), .select_bar_pin(sel),
      .out_or_addr_bit_pin(apin), .spi_data_out(spi_do),
      .spi_data_oe(spi_oe), .out_or_addr_bit_o(ao), .out_or_addr_bit_oe(aoe),
      .host_is_i2c(i2c), .slave_addr_lsb(alsb), .cfg_write(cfg_write),
      .align_on_irq2_select(on2), .align_function_select(mode),
      .align_output_enable(en), .gyro_range_select(rng),
      .output_rate_select(rate), .gyro_range(grng), .output_rate(orate),
      .irq1(irq1), .irq2(irq2), .align_out(al_out), .align_in(al_in),
      .align_enabled(al_en), .first_irq_pin(irq1_p), .second_irq_pin_i(i2p),
      .second_irq_pin_o(i2o), .second_irq_pin_oe(i2oe),
      .shared_align_kick_pin_i(kp), .shared_align_kick_pin_o(ko),
      .shared_align_kick_pin_oe(koe), .buffer_trigger(trig),
      .buffer_capacity_m1(cap), .side_scl_out(scl), .side_sda_out(sda),
      .side_bus_clock_pin_o(sclo), .side_bus_clock_pin_oe(scloe),
      .side_bus_data_pin_i(sdap), .side_bus_data_pin_o(sdao),
      .side_bus_data_pin_oe(sdaoe), .side_sda_in(sdain));
   task automatic chk(logic [11:0] got, logic [11:0] exp, string m);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic tick(int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic do_reset(logic i2c_strap, logic a);
      want_i2c = i2c_strap;
      addr_lsb = a;
      rst = 1;
      tick(3);
      chk(koe, 0, "align oe in reset");
      chk(al_en, 0, "align enabled in reset");
      rst = 0;
      tick(8);
   endtask
   task automatic cfg(logic o, logic [1:0] m, logic e, logic [2:0] r);
      on2 = o;
      mode = m;
      en = e;
      rng = r;
      cfg_write = 1;
      tick(1);
      cfg_write = 0;
      tick(3);
   endtask
   task automatic t_strap;
      do_reset(1, 1);
      spi_oe = 1;
      spi_do = 1;
      tick(2);
      chk(i2c, 1, "i2c mode");
      chk(alsb, 1, "addr lsb");
      chk(aoe, 0, "no spi drive in i2c");
      do_reset(0, 0);
      chk(i2c, 0, "spi mode");
      chk({aoe, ao}, 2'h3, "spi data drive");
      spi_oe = 0;
      chk(koe, 0, "align floats after reset");
      $display("test strap done");
   endtask
   task automatic t_routes;
      for (int i = 0; i < 8; i++) begin
         irq2 = i[0];
         al_out = !i[0];
         cfg(i[2], i[1:0], 1, 3'h2);
         chk(ko, !i[2] && i[1:0] != 0 && al_out, "kick pin data");
         chk(al_in, 0, "align in while driving");
         chk(i2oe, 1, "irq2 pin drive");
         chk(i2o, i[2] ? al_out : irq2, "irq2 pin source");
         chk(koe, !i[2] && i[1:0] != 0, "kick pin drive");
         chk(al_en, i[2] || i[1:0] != 0, "align enabled");
      end
      cfg(0, 0, 0, 3'h2);
      $display("test routes done");
   endtask
   task automatic t_align_in;
      cfg(1, 2'h0, 0, 3'h2);
      chk(i2oe, 0, "irq2 pin floats");
      chk(al_in, 1, "align in from irq2 pin");
      cfg(0, 2'h1, 0, 3'h2);
      kick_level = 1;
      repeat (8) begin
         tick(1);
         chk(trig, 0, "trigger while align routed");
      end
      chk({koe, al_in}, 2'h1, "align in from shared pin");
      kick_level = 0;
      cfg(0, 2'h0, 0, 3'h2);
      $display("test align input done");
   endtask
   task automatic t_trigger;
      int n = 0;
      kick_level = 1;
      repeat (12) begin
         tick(1);
         n += trig;
      end
      chk(n, 1, "one trigger pulse");
      kick_level = 0;
      tick(6);
      $display("test trigger done");
   endtask
   task automatic t_settings;
      logic [2:0] exp = 3'h2;
      for (int c = 0; c < 8; c++) begin
         rate = c[3:0] + 4'h8;
         cfg(0, 0, 0, c[2:0]);
         if (c <= 5) exp = c[2:0];
         chk(grng, exp, "gyro range");
         chk(orate, c[3:0] + 4'h8, "shared rate");
      end
      chk(cap, 12'hfff, "buffer size");
      $display("test settings done");
   endtask
   task automatic t_aux;
      scl = 0;
      sda = 1;
      irq1 = 1;
      tick(4);
      chk({scloe, sclo}, 2'h2, "aux clock low");
      chk({sdaoe, sdain}, 2'h1, "aux data released");
      chk(irq1_p, 1, "irq1 pin");
      scl = 1;
      sda = 0;
      tick(6);
      chk({scloe, sdaoe, sdao, sdain}, 4'h4, "aux swap");
      $display("test aux done");
   endtask
   task automatic give_verdict;
      $display("checks %0d fails %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      #20000;
      n_fail++;
      give_verdict();
   end
   initial begin
      t_strap();
      t_routes();
      t_align_in();
      t_trigger();
      t_settings();
      t_aux();
      give_verdict();
   end
endmodule // tb_mps_pin_mux
